// ---- common/tpg_consts.vh ----
// Purpose: Constants for the synthetic test pattern generator
// Assumes: Included by the pattern generator, its assertions and its testbench
// Notes:   Selector codes, widths and moduli
`ifndef TPG_CONSTS_VH
`define TPG_CONSTS_VH
`define SEL_OFF        3'h0
`define SEL_FIXED8     3'h1
`define SEL_MOVE8      3'h2
`define SEL_MOVE12     3'h3
`define SEL_FEAT8      3'h4
`define SEL_FEAT12     3'h5
`define SEL_COLOUR     3'h6
`define PIX_W          12
`define MASK8          12'h0ff
`define FIFO_DEPTH     8
`define COL_W          12
`define ROW_W          12
`define DEF_WIDTH      12'h280
`define DEF_HEIGHT     12'h1e0
`define YUV_U_OFS      8'h80
`endif

// ---- hw/pix_fifo.v ----
// Purpose: No logic of its own; the pixel FIFO module sits in the generator's file
// Assumes: Nothing
// Notes:   All design logic is kept in one file

// ---- hw/test_pattern_generator.v ----
// Purpose: Replace sensor pixels with synthetic frames, before or after the digital stage
// Assumes: Sensor and digital-stage streams are on clk_i, valid/ready handshake
// Notes:   Pattern pixels pass an 8-word FIFO; width/height are inputs
`timescale 1ns/1ps
`include "tpg_consts.vh"

// Notes on behaviour
// R01 - A selected pattern is built wholly here, never from the sensor path.
// R02 - Selector takes off or one of six pattern codes.
// R03 - Gain, black level and exposure cannot reach the output while a pattern runs.
// R04 - Patterns 1, 2, 3 and 6 enter after the digital stage.
// R05 - Patterns 4 and 5 enter before the digital stage and otherwise equal 2 and 3.
// R06 - Pattern 1 is (column + row) mod 256.
// R07 - Patterns 2 and 4 are (column + row + counter) mod 256.
// R08 - Patterns 3 and 5 are (column + row + counter) mod 4096.
// R09 - The counter steps by one on each acquisition start.
// R10 - Pattern 6 is a moving diagonal YUV gradient, colour variants only.
// R11 - Software should pair pattern 1 with mono 8-bit output.
// R12 - Indices start at zero each frame; counter clears on reset and wraps.
module test_pattern_generator #(
   parameter COLOUR = 1
) (
   input  wire                clk_i,
   input  wire                rst_n_i,
   input  wire [2:0]          synthetic_pattern_select_i,
   input  wire                acq_start_i,
   input  wire [`COL_W-1:0]   frame_width_i,
   input  wire [`ROW_W-1:0]   frame_height_i,
   input  wire [23:0]         sensor_data_i,
   input  wire                sensor_valid_i,
   input  wire                sensor_sof_i,
   output reg                 sensor_ready_o,
   output reg  [23:0]         proc_in_data_o,
   output reg                 proc_in_valid_o,
   output reg                 proc_in_sof_o,
   input  wire                proc_in_ready_i,
   input  wire [23:0]         proc_out_data_i,
   input  wire                proc_out_valid_i,
   input  wire                proc_out_sof_i,
   output reg                 proc_out_ready_o,
   output reg  [23:0]         tx_data_o,
   output reg                 tx_valid_o,
   output reg                 tx_sof_o,
   input  wire                tx_ready_i
);
   reg  [2:0]          sel_r;
   reg  [`PIX_W-1:0]   acq_cnt_r;
   reg  [`COL_W-1:0]   col_r;
   reg  [`ROW_W-1:0]   row_r;
   reg                 gen_active_r;
   wire                pat_on;
   wire                pre_stage;
   wire                fifo_in_ready;
   wire [24:0]         fifo_out;
   wire                fifo_valid;
   wire                fifo_ready;
   wire                gen_push;
   wire                last_col;
   wire                last_row;
   wire [`PIX_W-1:0]   diag;
   reg  [23:0]         pat_pix;
   wire [2:0]          sel_nxt;
   wire                pat_on_nxt;
   wire                pre_stage_nxt;
   wire                first_pix;
   wire                pi_load;
   wire                tx_load;
   wire                pi_valid_nxt;
   wire                tx_valid_nxt;

   function [`PIX_W-1:0] diag_sum;
      input [`COL_W-1:0] c;
      input [`ROW_W-1:0] r;
      input [`PIX_W-1:0] k;
      begin
         diag_sum = c + r + k;
      end
   endfunction

   // R02 R10 only valid codes; colour pattern only on colour builds
   function [2:0] sel_decode;
      input [2:0] code;
      begin
         if (code > `SEL_COLOUR) begin
            sel_decode = `SEL_OFF;
         end else if (code == `SEL_COLOUR && COLOUR == 0) begin
            sel_decode = `SEL_OFF;
         end else begin
            sel_decode = code;
         end
      end
   endfunction

   assign sel_nxt = acq_start_i ? sel_decode(synthetic_pattern_select_i) : sel_r;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_r <= `SEL_OFF;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   // R09 R12 one step per acquisition, natural wrap
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acq_cnt_r <= {`PIX_W{1'b0}};
      end else if (acq_start_i) begin
         acq_cnt_r <= acq_cnt_r + 1'b1;
      end
   end

   assign pat_on    = (sel_r != `SEL_OFF);
   // R04 R05 insertion point
   assign pre_stage = (sel_r == `SEL_FEAT8) || (sel_r == `SEL_FEAT12);
   assign pat_on_nxt    = (sel_nxt != `SEL_OFF);
   assign pre_stage_nxt = (sel_nxt == `SEL_FEAT8) || (sel_nxt == `SEL_FEAT12);
   assign pi_load   = ~proc_in_valid_o | proc_in_ready_i;
   assign tx_load   = ~tx_valid_o | tx_ready_i;
   assign first_pix = (col_r == {`COL_W{1'b0}}) && (row_r == {`ROW_W{1'b0}});
   assign last_col  = (col_r == frame_width_i - 1'b1);
   assign last_row  = (row_r == frame_height_i - 1'b1);
   assign gen_push  = gen_active_r & fifo_in_ready;
   // Moving patterns use the counter; fixed one does not
   assign diag      = diag_sum(col_r, row_r,
                               (sel_r == `SEL_FIXED8) ? {`PIX_W{1'b0}} : acq_cnt_r);

   // R06 R07 R08 R10 pixel value per pattern
   always @* begin
      case (sel_r)
         `SEL_FIXED8, `SEL_MOVE8, `SEL_FEAT8: begin
            pat_pix = {12'h000, diag & `MASK8};
         end
         `SEL_MOVE12, `SEL_FEAT12: begin
            pat_pix = {12'h000, diag};
         end
         `SEL_COLOUR: begin
            // Y ramps, U/V ramp against each other for hue change
            pat_pix = {diag[7:0], `YUV_U_OFS + diag[7:0], `YUV_U_OFS - diag[7:0]};
         end
         default: begin
            pat_pix = 24'h000000;
         end
      endcase
   end

   // R12 raster from zero; frame starts on acquisition
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         col_r        <= {`COL_W{1'b0}};
         row_r        <= {`ROW_W{1'b0}};
         gen_active_r <= 1'b0;
      end else if (acq_start_i) begin
         col_r        <= {`COL_W{1'b0}};
         row_r        <= {`ROW_W{1'b0}};
         // Refused codes must not start it: nothing would drain the FIFO
         gen_active_r <= pat_on_nxt;
      end else if (gen_push) begin
         if (last_col) begin
            col_r <= {`COL_W{1'b0}};
            if (last_row) begin
               row_r        <= {`ROW_W{1'b0}};
               gen_active_r <= 1'b0;
            end else begin
               row_r <= row_r + 1'b1;
            end
         end else begin
            col_r <= col_r + 1'b1;
         end
      end
   end

   // FIFO carries start-of-frame with each word
   pix_fifo #(
      .WIDTH (25),
      .DEPTH (`FIFO_DEPTH),
      .AW    (3)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_data_i   ({first_pix, pat_pix}),
      .in_valid_i  (gen_active_r),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_ready)
   );

   // Downstream stall reaches the generator through the FIFO
   assign fifo_ready = pat_on & (pre_stage ? pi_load : tx_load);

   // Each stage register reloads when empty or when its word is taken
   assign pi_valid_nxt = ~pi_load ? proc_in_valid_o :
                         pat_on   ? (pre_stage & fifo_valid) :
                                    (sensor_valid_i & sensor_ready_o);
   assign tx_valid_nxt = ~tx_load ? tx_valid_o :
                         (pat_on & ~pre_stage) ? fifo_valid :
                                    (proc_out_valid_i & proc_out_ready_o);

   // R01 R03 sensor is drained and dropped while a pattern runs
   // Ready is a flop, so it is raised only when the stage register will be empty;
   // an offered word then never meets a stall. Costs half the pass-through rate.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sensor_ready_o   <= 1'b0;
         proc_out_ready_o <= 1'b0;
      end else begin
         sensor_ready_o   <= pat_on_nxt | ~pi_valid_nxt;
         // R04 digital-stage output discarded for post-stage patterns
         proc_out_ready_o <= (pat_on_nxt & ~pre_stage_nxt) | ~tx_valid_nxt;
      end
   end

   // Input side of the digital stage
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         proc_in_data_o  <= 24'h000000;
         proc_in_valid_o <= 1'b0;
         proc_in_sof_o   <= 1'b0;
      end else begin
         proc_in_valid_o <= pi_valid_nxt;
         if (pi_load) begin
            if (pat_on) begin
               // R05 feature patterns feed the digital stage
               proc_in_data_o <= fifo_out[23:0];
               proc_in_sof_o  <= fifo_out[24];
            end else begin
               proc_in_data_o <= sensor_data_i;
               proc_in_sof_o  <= sensor_sof_i;
            end
         end
      end
   end

   // Transmit side
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_data_o  <= 24'h000000;
         tx_valid_o <= 1'b0;
         tx_sof_o   <= 1'b0;
      end else begin
         tx_valid_o <= tx_valid_nxt;
         if (tx_load) begin
            if (pat_on & ~pre_stage) begin
               // R04 bypass the digital stage
               tx_data_o <= fifo_out[23:0];
               tx_sof_o  <= fifo_out[24];
            end else begin
               tx_data_o <= proc_out_data_i;
               tx_sof_o  <= proc_out_sof_i;
            end
         end
      end
   end
endmodule // test_pattern_generator

// Pixel FIFO, valid/ready on both sides
// Full and empty come from an occupancy count; depth must be a power of two
module pix_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_r;
   reg [AW-1:0]    rd_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;

   assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
   assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_r];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Storage has no reset; words are only read behind the count
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_r] <= in_data_i;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_r  <= {AW{1'b0}};
         rd_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // pix_fifo

// ---- verification/tpg_sva.sv ----
// Purpose: Port checks for the pattern generator
// Assumes: Selector changes only together with acq_start_i
// Notes:   Acquisition count is mirrored in helper logic
`timescale 1ns/1ps
`include "tpg_consts.vh"
module tpg_sva (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire [2:0]  synthetic_pattern_select_i,
   input wire        acq_start_i,
   input wire [23:0] proc_in_data_o,
   input wire        proc_in_valid_o,
   input wire        proc_in_sof_o,
   input wire        proc_in_ready_i,
   input wire [23:0] tx_data_o,
   input wire        tx_valid_o,
   input wire        tx_sof_o,
   input wire        tx_ready_i
);
   wire [2:0]  s = synthetic_pattern_select_i;
   reg  [11:0] n_r;
   always @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i) n_r <= 12'h000;
      else if (acq_start_i) n_r <= n_r + 12'h001;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence tx_first;
      tx_valid_o && tx_sof_o;
   endsequence
   sequence late_start;
      acq_start_i && s inside {`SEL_FIXED8, `SEL_MOVE8, `SEL_MOVE12, `SEL_COLOUR};
   endsequence
   tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("tx word changed while stalled");
   pin_hold_a: assert property (proc_in_valid_o && !proc_in_ready_i |=> $stable(proc_in_data_o))
      else $error("stage word changed while stalled");
   start_lat_a: assert property (late_start |-> ##[1:8] tx_first)
      else $error("frame start missing on tx");
   fix_orig_a: assert property (tx_valid_o && tx_sof_o && s == `SEL_FIXED8
      |-> tx_data_o == 24'h000000)
      else $error("fixed ramp origin wrong");
   move_orig_a: assert property (tx_valid_o && tx_sof_o && s == `SEL_MOVE8
      |-> tx_data_o == {16'h0000, n_r[7:0]})
      else $error("moving ramp origin wrong");
   deep_orig_a: assert property (tx_valid_o && tx_sof_o && s == `SEL_MOVE12
      |-> tx_data_o == {12'h000, n_r})
      else $error("deep ramp origin wrong");
   feat_orig_a: assert property (proc_in_valid_o && proc_in_sof_o && s == `SEL_FEAT8
      |-> proc_in_data_o == {16'h0000, n_r[7:0]})
      else $error("feature ramp origin wrong");
   no_proc_a: assert property (s inside {`SEL_FIXED8, `SEL_MOVE8, `SEL_MOVE12}
      && !acq_start_i |-> !proc_in_valid_o)
      else $error("late pattern entered digital stage");
endmodule // tpg_sva
bind test_pattern_generator tpg_sva tpg_sva_i (.clk_i, .rst_n_i, .synthetic_pattern_select_i,
   .acq_start_i, .proc_in_data_o, .proc_in_valid_o, .proc_in_sof_o, .proc_in_ready_i,
   .tx_data_o, .tx_valid_o, .tx_sof_o, .tx_ready_i);

// ---- verification/dig_stage_model.sv ----
// Purpose: Digital stage stand-in with a lookup effect
// Assumes: Valid/ready on both sides
// Notes:   Inverts bits 7:0 so a bypass is visible
`timescale 1ns/1ps
module dig_stage_model (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire [23:0] in_data_i,
   input  wire        in_valid_i,
   input  wire        in_sof_i,
   output wire        in_ready_o,
   output reg  [23:0] out_data_o,
   output reg         out_valid_o,
   output reg         out_sof_o,
   input  wire        out_ready_i
);
   assign in_ready_o = !out_valid_o || out_ready_i;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_valid_o <= 1'b0;
         out_sof_o   <= 1'b0;
         out_data_o  <= 24'h000000;
      end else if (in_ready_o) begin
         out_valid_o <= in_valid_i;
         out_sof_o   <= in_sof_i;
         // Idle word flips so stale data never passes
         out_data_o  <= in_valid_i ? in_data_i ^ 24'h0000ff : ~out_data_o;
      end
   end
endmodule // dig_stage_model

// ---- verification/test_pattern_generator_tb.sv ----
// Purpose: Frame-by-frame check of all synthetic patterns
// Assumes: One acquisition at a time, frame drained before the next
// Notes:   Off and refused codes are checked as sensor pass-through
`timescale 1ns/1ps
`include "tpg_consts.vh"
module test_pattern_generator_tb;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, acq = 1'b0, en = 1'b0, tk = 1'b0;
   logic [2:0]  sel = 3'h0;
   logic [11:0] w = 12'h001, h = 12'h001;
   logic [23:0] s_data = 24'h000000, pi_data, po_data, tx_data;
   logic        s_valid = 1'b0, s_sof = 1'b0, tx_rdy = 1'b0, s_rdy;
   logic        pi_valid, pi_sof, pi_rdy, po_valid, po_sof, po_rdy, tx_valid, tx_sof;
   logic [24:0] q[$], sq[$];
   logic        pass_on = 1'b0;
   integer      seed = 47524, err_count = 0, num_checks = 0, i, p, t, acqs = 0;
   always #10 clk_i = ~clk_i;
   test_pattern_generator test_pattern_generator_i (.clk_i, .rst_n_i,
      .synthetic_pattern_select_i(sel), .acq_start_i(acq), .frame_width_i(w),
      .frame_height_i(h), .sensor_data_i(s_data), .sensor_valid_i(s_valid),
      .sensor_sof_i(s_sof), .sensor_ready_o(s_rdy), .proc_in_data_o(pi_data),
      .proc_in_valid_o(pi_valid), .proc_in_sof_o(pi_sof), .proc_in_ready_i(pi_rdy),
      .proc_out_data_i(po_data), .proc_out_valid_i(po_valid), .proc_out_sof_i(po_sof),
      .proc_out_ready_o(po_rdy), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
      .tx_sof_o(tx_sof), .tx_ready_i(tx_rdy));
   dig_stage_model dig_stage_model_i (.clk_i, .rst_n_i, .in_data_i(pi_data),
      .in_valid_i(pi_valid), .in_sof_i(pi_sof), .in_ready_o(pi_rdy), .out_data_o(po_data),
      .out_valid_o(po_valid), .out_sof_o(po_sof), .out_ready_i(po_rdy));
   // Pre-edge values: transfers seen exactly as the design takes them
   always @(posedge clk_i) begin
      tk <= s_valid && s_rdy;
      if (tx_valid === 1'b1 && tx_rdy === 1'b1) q.push_back({tx_sof, tx_data});
      if (pass_on && s_valid === 1'b1 && s_rdy === 1'b1) sq.push_back({s_sof, s_data ^ 24'h0000ff});
   end
   // sensor noise that must never show while a pattern runs
   always @(negedge clk_i) begin
      tx_rdy <= ($random(seed) % 4) != 0;
      if (!s_valid || tk) begin
         s_data  <= $random(seed);
         s_valid <= en && ($random(seed) % 2 != 0);
         s_sof   <= $random(seed) % 2 != 0;
      end
   end
   function automatic logic [23:0] pix(input logic [2:0] m, input logic [11:0] c, r, k);
      logic [11:0] v;
      v = c + r + ((m == `SEL_FIXED8) ? 12'h000 : k);
      pix = (m == `SEL_MOVE12 || m == `SEL_FEAT12) ? {12'h000, v} : {16'h0000, v[7:0]};
      if (m == `SEL_FEAT8 || m == `SEL_FEAT12) pix = pix ^ 24'h0000ff;
      if (m == `SEL_COLOUR) pix = {v[7:0], `YUV_U_OFS + v[7:0], `YUV_U_OFS - v[7:0]};
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] want);
      num_checks++;
      if (got !== want) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask
   // Off-mode frame: sensor words must reach tx through the stage model
   task automatic run_off(input logic [2:0] code);
      @(negedge clk_i);
      sel = code;
      sq.delete();
      q.delete();
      acq = 1'b1;
      acqs++;
      @(negedge clk_i) acq = 1'b0;
      pass_on = 1'b1;
      en = 1'b1;
      repeat (40) @(negedge clk_i);
      en = 1'b0;
      for (t = 0; t < 300 && (s_valid || q.size() < sq.size()); t++) @(negedge clk_i);
      repeat (8) @(negedge clk_i);
      pass_on = 1'b0;
      chk(24'(q.size()), 24'(sq.size()));
      for (p = 0; p < q.size() && p < sq.size(); p++) begin
         chk(q[p][23:0], sq[p][23:0]);
         chk(24'(q[p][24]), 24'(sq[p][24]));
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #1000000;
      err_count++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clk_i);
      @(negedge clk_i) rst_n_i = 1'b1;
      run_off(3'h0);
      for (i = 0; i < 14; i++) begin
         @(negedge clk_i);
         // pattern 1 runs first, as 8-bit words
         sel = (i < 6) ? 3'(i + 1) : 3'($unsigned($random(seed)) % 5 + 1);
         w = (i == 0) ? 12'h001 : 12'($unsigned($random(seed)) % 6 + 1);
         h = (i == 0) ? 12'h001 : 12'($unsigned($random(seed)) % 4 + 1);
         q.delete();
         acq = 1'b1;
         acqs++;
         @(negedge clk_i) acq = 1'b0;
         en = 1'b1;
         for (t = 0; t < 600 && q.size() < w * h; t++) @(negedge clk_i);
         repeat (4) @(negedge clk_i);
         chk(24'(q.size()), 24'(w * h));
         for (p = 0; p < q.size() && p < w * h; p++) begin
            chk(24'(q[p][24]), 24'(p == 0));
            chk(q[p][23:0], pix(sel, 12'(p % w), 12'(p / w), 12'(acqs)));
         end
      end
      run_off(3'h7);
      test_done;
   end
endmodule // test_pattern_generator_tb
